// >>> design/adc_track_hold_sequencer.sv
// Track/hold sequencing, serial slave framing and conversion control
//
// Summary of operation
// - Internal clock: track on eighth address rise
// - Internal clock: hold on ninth pulse fall
// - Internal clock: convert internally, hold serial clock low
// - External clock: track on read-bit rise
// - External clock: track ends on second result rise; sample_hold stays low
// - External clock: convert over next twelve cycles
// - Twelve cycles, one bit each, serial result
// - Track 1.5 periods internal; external 3 after the address, 2 on repeated reads
// - Single-ended: selected channel against ground
// - Differential: selected pair difference
// - Setup field selects shared pin function
// - Written byte top bit: setup or configuration
// - Address lowest bit selects write or read
// - Differential: binary unipolar, two's complement bipolar
// - Single-ended always unipolar
`timescale 1ns/100ps
module adc_track_hold_sequencer
  import adc_seq_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_scl,
  input wire logic sda_in,
  input wire logic comp_high,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic sample_track,
  output logic sample_hold,
  output logic [3:0] mux_channel,
  output logic mux_single,
  output logic [2:0] ref_select,
  output logic bipolar_coding,
  output logic [RES_BITS-1:0] dac_code_sys,
  output logic [RES_BITS-1:0] dac_code_link
);

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic start_seen;
    logic [2:0] ref_sel;
    logic ext_clk;
    logic bipolar;
    logic [3:0] cs;
    logic single;
    logic [3:0] mux_ch;
    logic mux_single;
    logic track;
    logic [4:0] pulse;
  } link_t;

  typedef struct packed {
    logic sda_oe;
    logic sda_out;
    logic hold;
  } fall_t;

  typedef struct packed {
    sys_state_t st;
    logic done;
    logic [RES_BITS-1:0] result;
  } sys_t;

  // ==========================================================
  // Functions
  // ==========================================================
  // Bit shown on the line during result pulse q (1 = released)
  function automatic logic tx_bit(input logic [4:0] q, input logic [RES_BITS-1:0] w);
    logic b;
    b = 1'b1;
    if (q == 5'h00 || q <= PAD_LAST_PULSE) begin
      b = 1'b1;
    end else if (q <= HIGH_NIBBLE_LAST) begin
      b = w[4'(5'd16 - q)];
    end else if (q == RESULT_ACK_PULSE) begin
      b = 1'b1;
    end else if (q <= LOW_BYTE_LAST) begin
      b = w[4'(5'd17 - q)];
    end
    return b;
  endfunction : tx_bit

  // Output code from raw comparison word
  function automatic logic [RES_BITS-1:0] coded(input logic [RES_BITS-1:0] raw, input logic bip);
    coded = bip ? (raw ^ BIPOLAR_FLIP) : raw;
  endfunction : coded

  // ==========================================================
  // Frame start detection
  // ==========================================================
  // Data falling while clock high; clocked by the data line itself
  // since no clock edge marks a start condition.
  logic start_tog_r;

  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tog_r <= 1'b0;
    end else if (link_scl) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  // ==========================================================
  // Link domain, rising edges
  // ==========================================================
  link_t l_r;
  link_t l_nxt;
  fall_t f_r;
  fall_t f_nxt;
  sys_t s_r;
  sys_t s_nxt;
  logic conv_req_r;
  logic ext_start;
  logic ext_busy;
  logic [RES_BITS-1:0] ext_code;
  logic [RES_BITS-1:0] tx_word;
  logic [7:0] rx_byte;

  assign rx_byte = {l_r.shreg[6:0], sda_in};
  // External mode conversion is paced by the serial clock
  assign ext_start = (l_r.phase == PH_RD) && l_r.ext_clk && (l_r.pulse == EXT_HOLD_PULSE);

  always_comb begin
    l_nxt = l_r;
    if (start_tog_r != l_r.start_seen) begin
      l_nxt.start_seen = start_tog_r;
      l_nxt.phase = PH_ADDR;
      l_nxt.bit_cnt = 4'h1;
      l_nxt.shreg = rx_byte;
      l_nxt.track = 1'b0;
    end else begin
      case (l_r.phase)
        PH_ADDR: begin
          l_nxt.shreg = rx_byte;
          l_nxt.bit_cnt = l_r.bit_cnt + 4'h1;
          if (l_r.bit_cnt == LAST_BIT_CNT) begin
            l_nxt.rw = sda_in;
            if (l_r.shreg[ADDR_BITS-1:0] == DEV_ADDR) begin
              l_nxt.phase = PH_ACK_ADDR;
              if (!l_r.ext_clk || sda_in) begin
                l_nxt.track = 1'b1;
                l_nxt.mux_ch = l_r.cs;
                l_nxt.mux_single = l_r.single;
              end
            end else begin
              l_nxt.phase = PH_IDLE;
            end
          end
        end
        PH_ACK_ADDR: begin
          l_nxt.bit_cnt = 4'h0;
          l_nxt.pulse = 5'h00;
          l_nxt.phase = l_r.rw ? PH_RD : PH_WR;
        end
        PH_WR: begin
          l_nxt.shreg = rx_byte;
          l_nxt.bit_cnt = l_r.bit_cnt + 4'h1;
          if (l_r.bit_cnt == 4'h0) begin
            l_nxt.track = 1'b0;
          end
          if (l_r.bit_cnt == LAST_BIT_CNT) begin
            l_nxt.phase = PH_ACK_WR;
            if (rx_byte[BYTE_KIND_BIT]) begin
              l_nxt.ref_sel = rx_byte[REF_SEL_HI:REF_SEL_LO];
              l_nxt.ext_clk = rx_byte[EXT_CLK_BIT];
              l_nxt.bipolar = rx_byte[POLARITY_BIT];
              if (!rx_byte[CFG_KEEP_BIT]) begin
                l_nxt.cs = CS_RESET;
                l_nxt.single = SINGLE_RESET;
              end
            end else begin
              l_nxt.cs = rx_byte[CS_HI:CS_LO];
              l_nxt.single = rx_byte[SINGLE_BIT];
            end
          end
        end
        PH_ACK_WR: begin
          l_nxt.bit_cnt = 4'h0;
          l_nxt.phase = PH_WR;
        end
        PH_RD: begin
          l_nxt.pulse = l_r.pulse + 5'h01;
          if (l_r.ext_clk && l_r.pulse == EXT_HOLD_PULSE) begin
            l_nxt.track = 1'b0;
          end
          if (!l_r.ext_clk && l_r.pulse == 5'h00) begin
            l_nxt.track = 1'b0;
          end
          if (!l_r.ext_clk && l_r.pulse == INT_RETRACK_PULSE) begin
            l_nxt.track = 1'b1;
            l_nxt.mux_ch = l_r.cs;
            l_nxt.mux_single = l_r.single;
          end
          if (l_r.pulse == MASTER_ACK_PULSE) begin
            if (sda_in) begin
              l_nxt.phase = PH_IDLE;
              l_nxt.track = 1'b0;
            end else begin
              l_nxt.pulse = 5'h00;
              if (l_r.ext_clk) begin
                l_nxt.track = 1'b1;
                l_nxt.mux_ch = l_r.cs;
                l_nxt.mux_single = l_r.single;
              end
            end
          end
        end
        default: begin
          l_nxt.phase = PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_scl or posedge rst) begin
    if (rst) begin
      l_r <= '{phase: PH_IDLE, bit_cnt: 4'h0, shreg: 8'h00, rw: 1'b0, start_seen: 1'b0,
               ref_sel: REF_SEL_RESET, ext_clk: EXT_CLK_RESET, bipolar: POLARITY_RESET,
               cs: CS_RESET, single: SINGLE_RESET, mux_ch: CS_RESET, mux_single: SINGLE_RESET,
               track: 1'b0, pulse: 5'h00};
    end else begin
      l_r <= l_nxt;
    end
  end

  // ==========================================================
  // Link domain, falling edges; external-clock converter on rising edges
  // ==========================================================
  // Live code in external mode: each bit is decided before it is shifted out
  assign tx_word = coded(l_r.ext_clk ? ext_code : s_r.result,
                         l_r.bipolar && !l_r.mux_single);

  always_comb begin
    f_nxt = f_r;
    f_nxt.sda_out = 1'b0;
    f_nxt.sda_oe = 1'b0;
    if (l_r.phase == PH_ACK_ADDR || l_r.phase == PH_ACK_WR) begin
      f_nxt.sda_oe = 1'b1;
    end else if (l_r.phase == PH_RD) begin
      f_nxt.sda_oe = ~tx_bit(l_r.pulse + 5'h01, tx_word);
    end
    if (l_r.phase == PH_ADDR || l_r.ext_clk) begin
      f_nxt.hold = 1'b0;
    end else if (l_r.phase == PH_RD && l_r.pulse == INT_RETRACK_PULSE + 5'h01) begin
      f_nxt.hold = 1'b0;
    end else if (l_r.track && ((l_r.phase == PH_RD && l_r.pulse == 5'h00) ||
                               (l_r.phase == PH_WR && l_r.bit_cnt == 4'h0))) begin
      f_nxt.hold = 1'b1;
    end
  end

  always_ff @(negedge link_scl or posedge rst) begin
    if (rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // Clock stretch: set on the hold edge, cleared once the result is ready.
  // The clear must be asynchronous because no clock edge arrives while held.
  always_ff @(negedge link_scl or posedge rst or posedge s_r.done) begin
    if (rst || s_r.done) begin
      conv_req_r <= 1'b0;
    end else if (!l_r.ext_clk && l_r.track && l_r.phase == PH_RD && l_r.pulse == 5'h00) begin
      conv_req_r <= 1'b1;
    end
  end

  sar_engine #(
    .W(RES_BITS)
  ) u_sar_link (
    .clk(link_scl),
    .rst(rst),
    .start(ext_start),
    .comp_high(comp_high),
    .code(ext_code),
    .busy(ext_busy),
    .done()
  );

  // ==========================================================
  // System domain: internally clocked conversion
  // ==========================================================
  logic req_s;
  logic sys_start;
  logic sys_done;
  logic [RES_BITS-1:0] sys_code;

  level_sync #(
    .W(1)
  ) u_req_sync (
    .clk(sys_clk),
    .rst(rst),
    .d(conv_req_r),
    .q(req_s)
  );

  assign sys_start = (s_r.st == SYS_IDLE) && req_s && !s_r.done;

  sar_engine #(
    .W(RES_BITS)
  ) u_sar_sys (
    .clk(sys_clk),
    .rst(rst),
    .start(sys_start),
    .comp_high(comp_high),
    .code(sys_code),
    .busy(),
    .done(sys_done)
  );

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      SYS_IDLE: begin
        if (sys_start) begin
          s_nxt.st = SYS_CONV;
        end
      end
      SYS_CONV: begin
        if (sys_done) begin
          s_nxt.result = sys_code;
          s_nxt.done = 1'b1;
          s_nxt.st = SYS_DONE;
        end
      end
      SYS_DONE: begin
        // Wait for the stretch request to drop before rearming
        if (!req_s) begin
          s_nxt.done = 1'b0;
          s_nxt.st = SYS_IDLE;
        end
      end
      default: begin
        s_nxt.st = SYS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: SYS_IDLE, done: 1'b0, result: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign scl_oe = conv_req_r;
  assign sda_out = f_r.sda_out;
  assign sda_oe = f_r.sda_oe;
  assign sample_track = l_r.track;
  assign sample_hold = f_r.hold;
  assign mux_channel = l_r.mux_ch;
  assign mux_single = l_r.mux_single;
  assign ref_select = l_r.ref_sel;
  assign bipolar_coding = l_r.bipolar;
  assign dac_code_sys = sys_code;
  assign dac_code_link = ext_code;

endmodule : adc_track_hold_sequencer

// >>> design/adc_seq_pkg.sv
// Shared constants and types for the converter track/hold sequencer
package adc_seq_pkg;

  // ==========================================================
  // Widths and identity
  // ==========================================================
  localparam int RES_BITS = 12;
  localparam int ADDR_BITS = 7;
  // Arbitrary neutral bus address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // ==========================================================
  // Setup byte fields
  // ==========================================================
  localparam int BYTE_KIND_BIT = 7;
  localparam int REF_SEL_HI = 6;
  localparam int REF_SEL_LO = 4;
  localparam int EXT_CLK_BIT = 3;
  localparam int POLARITY_BIT = 2;
  localparam int CFG_KEEP_BIT = 1;

  // ==========================================================
  // Configuration byte fields
  // ==========================================================
  localparam int CS_HI = 4;
  localparam int CS_LO = 1;
  localparam int SINGLE_BIT = 0;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [2:0] REF_SEL_RESET = 3'h0;
  localparam logic EXT_CLK_RESET = 1'b0;
  localparam logic POLARITY_RESET = 1'b0;
  localparam logic [3:0] CS_RESET = 4'h0;
  localparam logic SINGLE_RESET = 1'b1;

  // ==========================================================
  // Link timing, in serial-clock edges
  // ==========================================================
  localparam logic [3:0] LAST_BIT_CNT = 4'h7;
  localparam logic [4:0] EXT_HOLD_PULSE = 5'h01;
  localparam logic [4:0] INT_RETRACK_PULSE = 5'h10;
  localparam logic [4:0] MASTER_ACK_PULSE = 5'h11;
  localparam logic [4:0] PAD_LAST_PULSE = 5'h04;
  localparam logic [4:0] HIGH_NIBBLE_LAST = 5'h08;
  localparam logic [4:0] RESULT_ACK_PULSE = 5'h09;
  localparam logic [4:0] LOW_BYTE_LAST = 5'h11;
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_ACK_ADDR, PH_WR, PH_ACK_WR, PH_RD
  } phase_t;

  typedef enum logic [1:0] {
    SYS_IDLE, SYS_CONV, SYS_DONE
  } sys_state_t;

endpackage : adc_seq_pkg

// >>> design/level_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module level_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt.meta = d;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stable;
endmodule : level_sync

// >>> design/sar_engine.sv
// Successive-approximation register, one decision per clock
`timescale 1ns/100ps
module sar_engine #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic comp_high,
  output logic [W-1:0] code,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] code;
    logic [$clog2(W)-1:0] cnt;
    logic busy;
    logic done;
  } sar_t;

  sar_t r_r;
  sar_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    if (start) begin
      r_nxt.code = '0;
      r_nxt.code[W-1] = 1'b1;
      r_nxt.cnt = ($clog2(W))'(W - 1);
      r_nxt.busy = 1'b1;
    end else if (r_r.busy) begin
      // Comparator low means the trial overshot
      if (!comp_high) begin
        r_nxt.code[r_r.cnt] = 1'b0;
      end
      if (r_r.cnt == '0) begin
        r_nxt.busy = 1'b0;
        r_nxt.done = 1'b1;
      end else begin
        r_nxt.code[r_r.cnt - 1'b1] = 1'b1;
        r_nxt.cnt = r_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign code = r_r.code;
  assign busy = r_r.busy;
  assign done = r_r.done;
endmodule : sar_engine

// >>> testbench/adc_track_hold_sequencer_monitor.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
module adc_track_hold_sequencer_monitor
  import adc_seq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sample_track,
  input wire logic sample_hold,
  input wire logic [3:0] mux_channel,
  input wire logic mux_single,
  input wire logic [RES_BITS-1:0] dac_code_sys
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========
  // Stretch and hold
  a_stretch_hold: assert property (scl_oe |-> sample_hold)
    else $error("clock stretched outside hold");
  a_stretch_track: assert property ($rose(scl_oe) |-> sample_track)
    else $error("stretch without prior track");
  a_stretch_bound: assert property ($rose(scl_oe) |-> ##[1:40] !scl_oe)
    else $error("stretch never released");
  a_conv_length: assert property ($fell(scl_oe) |-> $past(scl_oe, 12))
    else $error("conversion shorter than twelve cycles");
  a_track_span: assert property ($rose(sample_hold) |-> $past(sample_track, 2))
    else $error("track interval too short");
  // Track may drop half a link period after hold, before this clock samples it
  a_hold_track: assert property ($rose(sample_hold) |-> $past(sample_track))
    else $error("hold without track");
  // ==========
  // Mux, code and data line
  a_mux_latch: assert property (!$stable({mux_channel, mux_single}) |-> sample_track)
    else $error("mux changed outside track");
  a_sar_quiet: assert property (!scl_oe && !$past(scl_oe) |-> $stable(dac_code_sys))
    else $error("trial code moved while idle");
  a_sda_open: assert property (sda_out == 1'b0)
    else $error("data line driven high");
endmodule : adc_track_hold_sequencer_monitor

// >>> testbench/bus_master_model.sv
// Two-wire bus master model with open-drain drive
`timescale 1ns/100ps
module bus_master_model #(
  parameter int HALF = 80
) (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_low,
  output logic sda_low
);
  int stalls;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stalls = 0;
  end
  // ==========
  // Bit and frame tasks
  task automatic clock_bit(input logic b, output logic got);
    int n;
    scl_low = 1'b1;
    #(HALF / 2) sda_low = !b;
    #(HALF / 2) scl_low = 1'b0;
    n = 0;
    // Device may hold the clock low while it converts
    while (scl_line !== 1'b1 && n < 400) begin
      #10 n++;
    end
    if (n == 400) begin
      stalls++;
      adc_track_hold_sequencer_test.stop_test();
    end
    got = sda_line;
    #HALF;
  endtask : clock_bit
  task automatic start_cond();
    sda_low = 1'b0;
    scl_low = 1'b0;
    #HALF sda_low = 1'b1;
    #HALF;
  endtask : start_cond
  task automatic stop_cond();
    scl_low = 1'b1;
    #(HALF / 2) sda_low = 1'b1;
    #(HALF / 2) scl_low = 1'b0;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], g);
    end
    clock_bit(1'b1, ack);
  endtask : send_byte
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, g);
      d[i] = g;
    end
    clock_bit(nack, g);
  endtask : read_byte
endmodule : bus_master_model

// >>> testbench/adc_track_hold_sequencer_test.sv
// Self-checking bench for the track/hold sequencer
`timescale 1ns/100ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module adc_track_hold_sequencer_test;
  import adc_seq_pkg::*;
  logic sys_clk, rst, comp_high, scl_oe, sda_out, sda_oe, sample_track, sample_hold;
  logic mux_single, bipolar_coding, scl_low, sda_low, ext_mode, ack, stretched;
  logic [3:0] mux_channel;
  logic [2:0] ref_select;
  logic [RES_BITS-1:0] dac_code_sys, dac_code_link, vin, res, expv;
  int fails, check_count;
  logic [7:0] setup_tab [5] = '{8'hD6, 8'hD6, 8'hD2, 8'hDA, 8'hDE};
  logic [7:0] cfg_tab [5] = '{8'h12, 8'h0B, 8'h12, 8'h0B, 8'h12};
  logic [11:0] vin_tab [5] = '{12'h3A5, 12'hC3E, 12'h7FF, 12'hFFF, 12'h001};
  // ==========
  // Wires, comparator and design
  wire logic scl_line = !(scl_low || scl_oe);
  wire logic sda_line = !(sda_low || sda_oe);
  // Ideal comparator, keeps a trial bit when input is at or above it
  assign comp_high = ((ext_mode ? dac_code_link : dac_code_sys) <= vin);
  always @(posedge scl_oe) stretched = 1'b1;
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  bus_master_model u_bus_master_model (.scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low),
    .sda_low(sda_low));
  adc_track_hold_sequencer u_adc_track_hold_sequencer (.sys_clk(sys_clk), .rst(rst), .link_scl(scl_line),
    .sda_in(sda_line), .comp_high(comp_high), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .sample_track(sample_track), .sample_hold(sample_hold), .mux_channel(mux_channel),
    .mux_single(mux_single), .ref_select(ref_select), .bipolar_coding(bipolar_coding),
    .dac_code_sys(dac_code_sys), .dac_code_link(dac_code_link));
  // ==========
  // Access tasks
  task automatic write_byte(input logic [7:0] b);
    logic a;
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte({DEV_ADDR_DEFAULT, 1'b0}, a);
    `CHECK(a, 1'b0)
    u_bus_master_model.send_byte(b, a);
    `CHECK(a, 1'b0)
    u_bus_master_model.stop_cond();
  endtask : write_byte
  task automatic read_result(input logic [6:0] addr, output logic a, output logic [11:0] r);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = 8'h00;
    lo = 8'h00;
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte({addr, 1'b1}, a);
    if (a === 1'b0) begin
      u_bus_master_model.read_byte(1'b0, hi);
      u_bus_master_model.read_byte(1'b1, lo);
      `CHECK(hi[7:4], 4'hF)
    end
    u_bus_master_model.stop_cond();
    r = {hi[3:0], lo};
  endtask : read_result
  task automatic stop_test();
    fails = fails + u_bus_master_model.stalls;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // ==========
  // Test sequence
  initial begin
    rst = 1'b1;
    vin = 12'h000;
    ext_mode = 1'b0;
    stretched = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    #2 rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHECK({mux_single, mux_channel, ref_select, bipolar_coding, scl_oe, sda_oe}, 11'h400)
    $display("test reset_defaults done");
    for (int r = 0; r < 8; r++) begin
      write_byte({1'b1, r[2:0], 4'h2});
      `CHECK(ref_select, r[2:0])
    end
    write_byte(8'h12);
    `CHECK(ref_select, 3'h7)
    $display("test setup_config_bytes done");
    // Each row: setup, configuration, comparator level
    for (int i = 0; i < 5; i++) begin
      write_byte(setup_tab[i]);
      write_byte(cfg_tab[i]);
      ext_mode = setup_tab[i][3];
      vin = vin_tab[i];
      stretched = 1'b0;
      expv = vin_tab[i] ^ ((!cfg_tab[i][0] && setup_tab[i][2]) ? 12'h800 : 12'h000);
      read_result(DEV_ADDR_DEFAULT, ack, res);
      `CHECK(ack, 1'b0)
      `CHECK(res, expv)
      `CHECK({mux_channel, mux_single}, cfg_tab[i][4:0])
      `CHECK(bipolar_coding, setup_tab[i][2])
      `CHECK(stretched, !ext_mode)
    end
    $display("test conversions done");
    read_result(DEV_ADDR_DEFAULT ^ 7'h01, ack, res);
    `CHECK(ack, 1'b1)
    $display("test foreign_address done");
    // Setup byte with bit 1 low returns the configuration to defaults
    write_byte(8'hD0);
    ext_mode = 1'b0;
    vin = 12'h5A5;
    read_result(DEV_ADDR_DEFAULT, ack, res);
    `CHECK(res, 12'h5A5)
    `CHECK({mux_channel, mux_single}, {CS_RESET, SINGLE_RESET})
    $display("test config_defaults done");
    stop_test();
  end
endmodule : adc_track_hold_sequencer_test
bind adc_track_hold_sequencer adc_track_hold_sequencer_monitor u_adc_track_hold_sequencer_monitor (
  .sys_clk(sys_clk), .rst(rst), .scl_oe(scl_oe), .sda_out(sda_out), .sample_track(sample_track),
  .sample_hold(sample_hold), .mux_channel(mux_channel), .mux_single(mux_single), .dac_code_sys(dac_code_sys));
